// ===== smt_defs.svh
// timing constants for the special move and arithmetic timing model
`ifndef SMT_DEFS_SVH
`define SMT_DEFS_SVH
`define SMT_CLK_PERIOD_NS 10
`define SMT_CNT_W 10
`define SMT_BUS_W 6
`define SMT_NREG_W 5
`define SMT_MLOAD_BASE 10'h008
`define SMT_MLOAD_WBASE 10'h009
`define SMT_MLOAD_PER 10'h004
`define SMT_MSTORE_BASE 10'h004
`define SMT_MSTORE_WBASE 10'h005
`define SMT_MSTORE_PER 10'h003
`define SMT_BUSY_MIN 10'h001
`endif

// ===== smt_pkg.sv
// types for the special move and arithmetic timing model
package smt_pkg;
  typedef enum logic [4:0] {
    SMT_OP_EXCHANGE = 5'h00,
    SMT_OP_CTL_TO_REG = 5'h01,
    SMT_OP_REG_TO_CTL = 5'h02,
    SMT_OP_PSW_TO_REG = 5'h03,
    SMT_OP_PSW_TO_MEM = 5'h04,
    SMT_OP_EA_TO_CCR = 5'h05,
    SMT_OP_EA_TO_SR = 5'h06,
    SMT_OP_MULTI_LOAD = 5'h07,
    SMT_OP_MULTI_STORE = 5'h08,
    SMT_OP_LANE_W_TO_MEM = 5'h09,
    SMT_OP_LANE_L_TO_MEM = 5'h0A,
    SMT_OP_LANE_W_TO_REG = 5'h0B,
    SMT_OP_LANE_L_TO_REG = 5'h0C,
    SMT_OP_ALT_TO_REG = 5'h0D,
    SMT_OP_ALT_TO_MEM = 5'h0E,
    SMT_OP_USP_MOVE = 5'h0F,
    SMT_OP_SWAP = 5'h10,
    SMT_OP_ALU_TO_REG = 5'h11,
    SMT_OP_ALU_TO_MEM = 5'h12,
    SMT_OP_CMP_ADDR = 5'h13,
    SMT_OP_RANGE_COMPARE = 5'h14,
    SMT_OP_WORD_MULTIPLY = 5'h15,
    SMT_OP_LONG_MULTIPLY = 5'h16,
    SMT_OP_WORD_UDIVIDE = 5'h17,
    SMT_OP_LONG_UDIVIDE = 5'h18,
    SMT_OP_WORD_SDIVIDE = 5'h19,
    SMT_OP_LONG_SDIVIDE = 5'h1A,
    SMT_OP_QUICK_TO_REG = 5'h1B,
    SMT_OP_QUICK_TO_MEM = 5'h1C,
    SMT_OP_IMM_TO_REG = 5'h1D,
    SMT_OP_IMM_TO_MEM = 5'h1E
  } smt_op_t;
  // fetch-immediate and calculate-immediate address times are separate
  typedef enum logic [2:0] {
    SMT_ADD_NONE = 3'h0,
    SMT_ADD_FETCH_EA = 3'h1,
    SMT_ADD_CALC_EA = 3'h2,
    SMT_ADD_IMM_ADDR = 3'h3,
    SMT_ADD_CALC_IMM = 3'h4
  } smt_add_t;
  typedef enum logic [1:0] {
    SMT_CASE_BEST = 2'h0,
    SMT_CASE_CACHE = 2'h1,
    SMT_CASE_WORST = 2'h2
  } smt_case_t;
  typedef enum logic [0:0] {
    SMT_ST_IDLE = 1'b0,
    SMT_ST_RUN = 1'b1
  } smt_state_t;
endpackage : smt_pkg

// ===== smt_entry_lookup.sv
// lookup of one case figure and its bus-cycle triple
`include "smt_defs.svh"
module smt_entry_lookup
  import smt_pkg::*;
(
  // request
  input wire smt_pkg::smt_op_t op,
  input wire smt_pkg::smt_case_t whichCase,
  input wire logic [`SMT_NREG_W-1:0] regCount,
  // result
  output logic [`SMT_CNT_W-1:0] clocks,
  output logic [`SMT_BUS_W-1:0] reads,
  output logic [`SMT_BUS_W-1:0] prefetches,
  output logic [`SMT_BUS_W-1:0] writes,
  output smt_pkg::smt_add_t addTime
);
  import smt_pkg::*;

  // picks one of three case figures
  function automatic logic [`SMT_CNT_W-1:0] pick3(
    input smt_case_t c, input int b, input int k, input int w);
    logic [`SMT_CNT_W-1:0] r;
    r = (c == SMT_CASE_BEST) ? b[`SMT_CNT_W-1:0] :
        (c == SMT_CASE_CACHE) ? k[`SMT_CNT_W-1:0] : w[`SMT_CNT_W-1:0];
    return r;
  endfunction : pick3

  logic worst;
  logic [`SMT_CNT_W-1:0] n10;
  assign worst = (whichCase == SMT_CASE_WORST);
  assign n10 = {{(`SMT_CNT_W-`SMT_NREG_W){1'b0}}, regCount};

  // table decode
  always_comb begin
    clocks = '0;
    reads = '0;
    writes = '0;
    addTime = SMT_ADD_NONE;
    prefetches = worst ? 6'h01 : 6'h00;
    case (op)
      SMT_OP_EXCHANGE, SMT_OP_USP_MOVE: clocks = pick3(whichCase, 0, 2, 3);
      SMT_OP_CTL_TO_REG: clocks = pick3(whichCase, 3, 6, 7);
      SMT_OP_REG_TO_CTL: clocks = pick3(whichCase, 9, 12, 13);
      SMT_OP_PSW_TO_REG: clocks = pick3(whichCase, 1, 4, 5);
      SMT_OP_PSW_TO_MEM: begin
        clocks = pick3(whichCase, 5, 5, 7);
        writes = 6'h01;
        addTime = SMT_ADD_CALC_EA;
      end
      SMT_OP_EA_TO_CCR: begin
        clocks = pick3(whichCase, 4, 4, 5);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_EA_TO_SR: begin
        clocks = pick3(whichCase, 8, 8, 11);
        prefetches = worst ? 6'h02 : 6'h00;
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_MULTI_LOAD: begin
        clocks = (worst ? `SMT_MLOAD_WBASE : `SMT_MLOAD_BASE)
                 + 10'((n10 * `SMT_MLOAD_PER));
        reads = {1'b0, regCount};
        addTime = SMT_ADD_CALC_IMM;
      end
      SMT_OP_MULTI_STORE: begin
        clocks = (worst ? `SMT_MSTORE_WBASE : `SMT_MSTORE_BASE)
                 + 10'((n10 * `SMT_MSTORE_PER));
        writes = {1'b0, regCount};
        addTime = SMT_ADD_CALC_IMM;
      end
      SMT_OP_LANE_W_TO_MEM: begin
        clocks = pick3(whichCase, 8, 11, 11);
        writes = 6'h02;
      end
      SMT_OP_LANE_L_TO_MEM: begin
        clocks = pick3(whichCase, 14, 17, 17);
        writes = 6'h04;
      end
      SMT_OP_LANE_W_TO_REG: begin
        clocks = pick3(whichCase, 10, 12, 12);
        reads = 6'h02;
      end
      SMT_OP_LANE_L_TO_REG: begin
        clocks = pick3(whichCase, 16, 18, 18);
        reads = 6'h04;
      end
      SMT_OP_ALT_TO_REG: begin
        clocks = pick3(whichCase, 7, 7, 8);
        reads = 6'h01;
        addTime = SMT_ADD_CALC_IMM;
      end
      SMT_OP_ALT_TO_MEM: begin
        clocks = pick3(whichCase, 5, 5, 7);
        writes = 6'h01;
        addTime = SMT_ADD_CALC_IMM;
      end
      SMT_OP_SWAP: clocks = pick3(whichCase, 1, 4, 4);
      SMT_OP_ALU_TO_REG: begin
        clocks = pick3(whichCase, 0, 2, 3);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_ALU_TO_MEM: begin
        clocks = pick3(whichCase, 3, 4, 6);
        writes = 6'h01;
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_CMP_ADDR: begin
        clocks = pick3(whichCase, 1, 4, 4);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_RANGE_COMPARE: begin
        clocks = pick3(whichCase, 16, 18, 18);
        reads = 6'h01;
        addTime = SMT_ADD_IMM_ADDR;
      end
      SMT_OP_WORD_MULTIPLY: begin
        clocks = pick3(whichCase, 25, 27, 28);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_LONG_MULTIPLY: begin
        clocks = pick3(whichCase, 41, 43, 44);
        addTime = SMT_ADD_IMM_ADDR;
      end
      SMT_OP_WORD_UDIVIDE: begin
        clocks = pick3(whichCase, 42, 44, 44);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_LONG_UDIVIDE: begin
        clocks = pick3(whichCase, 76, 78, 79);
        addTime = SMT_ADD_IMM_ADDR;
      end
      SMT_OP_WORD_SDIVIDE: begin
        clocks = pick3(whichCase, 54, 56, 57);
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_LONG_SDIVIDE: begin
        clocks = pick3(whichCase, 88, 90, 91);
        addTime = SMT_ADD_IMM_ADDR;
      end
      SMT_OP_QUICK_TO_REG: clocks = pick3(whichCase, 0, 2, 3);
      SMT_OP_QUICK_TO_MEM: begin
        clocks = pick3(whichCase, 3, 4, 6);
        writes = 6'h01;
        addTime = SMT_ADD_FETCH_EA;
      end
      SMT_OP_IMM_TO_REG: begin
        clocks = pick3(whichCase, 0, 2, 3);
        addTime = SMT_ADD_IMM_ADDR;
      end
      SMT_OP_IMM_TO_MEM: begin
        clocks = pick3(whichCase, 3, 4, 6);
        writes = 6'h01;
        addTime = SMT_ADD_IMM_ADDR;
      end
      default: clocks = '0;
    endcase
  end
endmodule : smt_entry_lookup

// ===== smt_timing_model.sv
// timing model: answers three case figures and runs an execution counter
`include "smt_defs.svh"
module smt_timing_model
  import smt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // request
  input wire logic reqValid,
  input wire smt_pkg::smt_op_t reqOp,
  input wire logic [`SMT_NREG_W-1:0] reqRegCount,
  input wire smt_pkg::smt_case_t runCase,
  // answer
  output logic reqReady,
  output logic ansValid,
  output logic [`SMT_CNT_W-1:0] bestClocks,
  output logic [`SMT_CNT_W-1:0] cacheClocks,
  output logic [`SMT_CNT_W-1:0] worstClocks,
  output logic [3*`SMT_BUS_W-1:0] bestBus,
  output logic [3*`SMT_BUS_W-1:0] cacheBus,
  output logic [3*`SMT_BUS_W-1:0] worstBus,
  output smt_pkg::smt_add_t addTime,
  // execution timing
  output logic execBusy,
  output logic execDone
);
  import smt_pkg::*;

  logic [`SMT_CNT_W-1:0] clk0, clk1, clk2;
  logic [`SMT_BUS_W-1:0] rd0, rd1, rd2, pf0, pf1, pf2, wr0, wr1, wr2;
  smt_add_t add0, add1, add2;

  // one lookup per case so all three answer together
  smt_entry_lookup uBest (
    .op(reqOp), .whichCase(SMT_CASE_BEST), .regCount(reqRegCount),
    .clocks(clk0), .reads(rd0), .prefetches(pf0), .writes(wr0),
    .addTime(add0)
  );
  smt_entry_lookup uCache (
    .op(reqOp), .whichCase(SMT_CASE_CACHE), .regCount(reqRegCount),
    .clocks(clk1), .reads(rd1), .prefetches(pf1), .writes(wr1),
    .addTime(add1)
  );
  smt_entry_lookup uWorst (
    .op(reqOp), .whichCase(SMT_CASE_WORST), .regCount(reqRegCount),
    .clocks(clk2), .reads(rd2), .prefetches(pf2), .writes(wr2),
    .addTime(add2)
  );

  smt_state_t state_r, state_nxt;
  logic [`SMT_CNT_W-1:0] count_r, count_nxt;
  logic ansValid_r, ansValid_nxt, done_r, done_nxt;
  logic [`SMT_CNT_W-1:0] best_r, best_nxt, cache_r, cache_nxt;
  logic [`SMT_CNT_W-1:0] worst_r, worst_nxt;
  logic [3*`SMT_BUS_W-1:0] bb_r, bb_nxt, cb_r, cb_nxt, wb_r, wb_nxt;
  smt_add_t add_r, add_nxt;
  logic [`SMT_CNT_W-1:0] runClocks;
  logic take;

  assign reqReady = (state_r == SMT_ST_IDLE);
  assign take = reqValid && reqReady;
  // zero-clock forms still take one cycle of the counter
  assign runClocks = (runCase == SMT_CASE_BEST) ? clk0 :
                     (runCase == SMT_CASE_CACHE) ? clk1 : clk2;

  // next state: capture answer, count down the chosen case
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    ansValid_nxt = 1'b0;
    done_nxt = 1'b0;
    best_nxt = best_r;
    cache_nxt = cache_r;
    worst_nxt = worst_r;
    bb_nxt = bb_r;
    cb_nxt = cb_r;
    wb_nxt = wb_r;
    add_nxt = add_r;
    case (state_r)
      SMT_ST_IDLE: begin
        if (take) begin
          ansValid_nxt = 1'b1;
          best_nxt = clk0;
          cache_nxt = clk1;
          worst_nxt = clk2;
          bb_nxt = {rd0, pf0, wr0};
          cb_nxt = {rd1, pf1, wr1};
          wb_nxt = {rd2, pf2, wr2};
          add_nxt = add0;
          count_nxt = (runClocks > `SMT_BUSY_MIN) ? runClocks
                                                  : `SMT_BUSY_MIN;
          state_nxt = SMT_ST_RUN;
        end
      end
      SMT_ST_RUN: begin
        if (count_r == `SMT_BUSY_MIN) begin
          done_nxt = 1'b1;
          state_nxt = SMT_ST_IDLE;
        end else begin
          count_nxt = count_r - `SMT_BUSY_MIN;
        end
      end
      default: state_nxt = SMT_ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SMT_ST_IDLE;
      count_r <= '0;
      ansValid_r <= 1'b0;
      done_r <= 1'b0;
      best_r <= '0;
      cache_r <= '0;
      worst_r <= '0;
      bb_r <= '0;
      cb_r <= '0;
      wb_r <= '0;
      add_r <= SMT_ADD_NONE;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      ansValid_r <= ansValid_nxt;
      done_r <= done_nxt;
      best_r <= best_nxt;
      cache_r <= cache_nxt;
      worst_r <= worst_nxt;
      bb_r <= bb_nxt;
      cb_r <= cb_nxt;
      wb_r <= wb_nxt;
      add_r <= add_nxt;
    end
  end

  // outputs from flops
  assign ansValid = ansValid_r;
  assign bestClocks = best_r;
  assign cacheClocks = cache_r;
  assign worstClocks = worst_r;
  assign bestBus = bb_r;
  assign cacheBus = cb_r;
  assign worstBus = wb_r;
  assign addTime = add_r;
  assign execBusy = (state_r == SMT_ST_RUN);
  assign execDone = done_r;
endmodule : smt_timing_model

// ===== smt_timing_model_checker.sv
// checker for the timing model answer and execution counter
`include "smt_defs.svh"
module smt_timing_model_checker
  import smt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // request
  input wire logic reqValid,
  input wire smt_pkg::smt_op_t reqOp,
  input wire logic [`SMT_NREG_W-1:0] reqRegCount,
  input wire smt_pkg::smt_case_t runCase,
  // answer
  input wire logic reqReady,
  input wire logic ansValid,
  input wire logic [`SMT_CNT_W-1:0] bestClocks,
  input wire logic [`SMT_CNT_W-1:0] cacheClocks,
  input wire logic [`SMT_CNT_W-1:0] worstClocks,
  input wire logic [3*`SMT_BUS_W-1:0] bestBus,
  input wire logic [3*`SMT_BUS_W-1:0] cacheBus,
  input wire logic [3*`SMT_BUS_W-1:0] worstBus,
  input wire smt_pkg::smt_add_t addTime,
  // execution timing
  input wire logic execBusy,
  input wire logic execDone
);
  import smt_pkg::*;

  smt_case_t caseSel_r, caseSel_nxt;
  logic [9:0] cnt_r, cnt_nxt, exp_r, exp_nxt, pick;
  // latch the case at take, start counting when the answer shows
  always_comb begin
    caseSel_nxt = caseSel_r;
    cnt_nxt = cnt_r + 10'h001;
    exp_nxt = exp_r;
    pick = (caseSel_r == SMT_CASE_BEST) ? bestClocks :
      (caseSel_r == SMT_CASE_CACHE) ? cacheClocks : worstClocks;
    if (reqValid && reqReady) caseSel_nxt = runCase;
    if (ansValid) begin
      cnt_nxt = 10'h001;
      // zero-clock forms still spend one cycle
      exp_nxt = (pick == 10'h000) ? 10'h001 : pick;
    end
  end
  // helper registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      caseSel_r <= SMT_CASE_BEST;
      cnt_r <= 10'h000;
      exp_r <= 10'h000;
    end else begin
      caseSel_r <= caseSel_nxt;
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence sTake;
    reqValid && reqReady;
  endsequence
  sequence sAnswer;
    ansValid && execBusy && !reqReady;
  endsequence
  AST_ANSWER: assert property (sTake |=> sAnswer)
    else $error("no answer one cycle after take");
  AST_ANS_CAUSE: assert property (ansValid |-> $past(reqValid && reqReady))
    else $error("answer without take");
  AST_DONE_BOUND: assert property (sTake |-> ##[2:200] execDone)
    else $error("execution count never ended");
  AST_DONE_COUNT: assert property (execDone |-> cnt_r == exp_r)
    else $error("execution count differs from case total");
  AST_BUSY_END: assert property ($fell(execBusy) |-> execDone && reqReady)
    else $error("busy fell without done");
  AST_PREFETCH: assert property (ansValid |-> bestBus[11:6] == 6'h00
    && cacheBus[11:6] == 6'h00 && worstBus[11:6] != 6'h00)
    else $error("worst case prefetch wrong");
  AST_SAME_DATA: assert property (ansValid |-> cacheBus == bestBus
    && bestBus[17:12] == worstBus[17:12] && bestBus[5:0] == worstBus[5:0])
    else $error("data cycles differ between cases");
  AST_ORDER: assert property (ansValid |-> bestClocks <= cacheClocks
    && cacheClocks <= worstClocks)
    else $error("case totals out of order");
  AST_MLOAD: assert property (ansValid && $past(reqOp) == SMT_OP_MULTI_LOAD
    |-> worstClocks == 10'h009 + 10'h004 * $past(reqRegCount))
    else $error("multi load worst total wrong");
  AST_HOLD: assert property (!(reqValid && reqReady) |=> $stable(worstClocks)
    && $stable(addTime) && $stable(bestBus))
    else $error("figures changed without take");
  // a take may fall on the done cycle, so each pulse is judged alone
  AST_ANS_PULSE: assert property (ansValid |=> !ansValid)
    else $error("answer pulse longer than one cycle");
  AST_DONE_PULSE: assert property (execDone |=> !execDone)
    else $error("done pulse longer than one cycle");
endmodule : smt_timing_model_checker

bind smt_timing_model smt_timing_model_checker smt_timing_model_checker_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqOp(reqOp),
  .reqRegCount(reqRegCount), .runCase(runCase), .reqReady(reqReady),
  .ansValid(ansValid), .bestClocks(bestClocks), .cacheClocks(cacheClocks),
  .worstClocks(worstClocks), .bestBus(bestBus), .cacheBus(cacheBus),
  .worstBus(worstBus), .addTime(addTime), .execBusy(execBusy),
  .execDone(execDone));

// ===== tb_smt_timing_model.sv
// testbench for the timing model
module tb_smt_timing_model import smt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, sys_rst, reqValid, reqReady, ansValid, execBusy, execDone;
  smt_op_t reqOp;
  logic [4:0] reqRegCount;
  smt_case_t runCase;
  logic [9:0] bestClocks, cacheClocks, worstClocks;
  logic [17:0] bestBus, cacheBus, worstBus;
  smt_add_t addTime;
  int miscompares = 0;
  int nChecks = 0;
  // device under test
  smt_timing_model smt_timing_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqOp(reqOp), .reqRegCount(reqRegCount),
    .runCase(runCase), .reqReady(reqReady), .ansValid(ansValid),
    .bestClocks(bestClocks), .cacheClocks(cacheClocks),
    .worstClocks(worstClocks), .bestBus(bestBus), .cacheBus(cacheBus),
    .worstBus(worstBus), .addTime(addTime), .execBusy(execBusy),
    .execDone(execDone));
  // clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [63:0] e, s);
    nChecks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    if (miscompares == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // one request; cache bus assumed equal to best bus
  task automatic pr(input smt_op_t op, input logic [4:0] n,
    input smt_case_t cs, input logic [9:0] b, c, w,
    input logic [17:0] bb, wb, input smt_add_t ad);
    int k;
    logic [9:0] want;
    want = (cs == SMT_CASE_BEST) ? b : (cs == SMT_CASE_CACHE) ? c : w;
    if (want == 10'h000) want = 10'h001;
    reqOp = op;
    reqRegCount = n;
    runCase = cs;
    reqValid = 1'b1;
    @(posedge ref_clk); #1;
    reqValid = 1'b0;
    chk("ansValid", 64'h1, {63'h0, ansValid});
    chk("clocks", {b, c, w}, {bestClocks, cacheClocks, worstClocks});
    chk("bus", {bb, bb, wb}, {bestBus, cacheBus, worstBus});
    chk("addTime", ad, addTime);
    k = 0;
    while (execDone !== 1'b1 && k < 300) begin
      @(posedge ref_clk); #1;
      k++;
    end
    chk("cycles", want, k[9:0]);
  endtask : pr
  task automatic t_control;
    pr(SMT_OP_REG_TO_CTL, 5'h00, SMT_CASE_WORST, 10'h009, 10'h00C,
      10'h00D, 18'h00000, 18'h00040, SMT_ADD_NONE);
    pr(SMT_OP_CTL_TO_REG, 5'h00, SMT_CASE_CACHE, 10'h003, 10'h006,
      10'h007, 18'h00000, 18'h00040, SMT_ADD_NONE);
  endtask : t_control
  task automatic t_multi;
    pr(SMT_OP_MULTI_LOAD, 5'h1F, SMT_CASE_WORST, 10'h084, 10'h084,
      10'h085, 18'h1F000, 18'h1F040, SMT_ADD_CALC_IMM);
    pr(SMT_OP_MULTI_STORE, 5'h03, SMT_CASE_BEST, 10'h00D, 10'h00D,
      10'h00E, 18'h00003, 18'h00043, SMT_ADD_CALC_IMM);
    pr(SMT_OP_ALT_TO_MEM, 5'h00, SMT_CASE_CACHE, 10'h005, 10'h005,
      10'h007, 18'h00001, 18'h00041, SMT_ADD_CALC_IMM);
  endtask : t_multi
  task automatic t_lane;
    pr(SMT_OP_LANE_W_TO_MEM, 5'h00, SMT_CASE_BEST, 10'h008, 10'h00B,
      10'h00B, 18'h00002, 18'h00042, SMT_ADD_NONE);
    pr(SMT_OP_LANE_L_TO_MEM, 5'h00, SMT_CASE_WORST, 10'h00E, 10'h011,
      10'h011, 18'h00004, 18'h00044, SMT_ADD_NONE);
    pr(SMT_OP_LANE_W_TO_REG, 5'h00, SMT_CASE_CACHE, 10'h00A, 10'h00C,
      10'h00C, 18'h02000, 18'h02040, SMT_ADD_NONE);
    pr(SMT_OP_LANE_L_TO_REG, 5'h00, SMT_CASE_BEST, 10'h010, 10'h012,
      10'h012, 18'h04000, 18'h04040, SMT_ADD_NONE);
  endtask : t_lane
  task automatic t_status;
    pr(SMT_OP_PSW_TO_MEM, 5'h00, SMT_CASE_WORST, 10'h005, 10'h005,
      10'h007, 18'h00001, 18'h00041, SMT_ADD_CALC_EA);
    pr(SMT_OP_EA_TO_SR, 5'h00, SMT_CASE_WORST, 10'h008, 10'h008,
      10'h00B, 18'h00000, 18'h00080, SMT_ADD_FETCH_EA);
  endtask : t_status
  task automatic t_long;
    pr(SMT_OP_LONG_MULTIPLY, 5'h00, SMT_CASE_CACHE, 10'h029, 10'h02B,
      10'h02C, 18'h00000, 18'h00040, SMT_ADD_IMM_ADDR);
    pr(SMT_OP_LONG_UDIVIDE, 5'h00, SMT_CASE_WORST, 10'h04C, 10'h04E,
      10'h04F, 18'h00000, 18'h00040, SMT_ADD_IMM_ADDR);
    pr(SMT_OP_RANGE_COMPARE, 5'h00, SMT_CASE_BEST, 10'h010, 10'h012,
      10'h012, 18'h01000, 18'h01040, SMT_ADD_IMM_ADDR);
  endtask : t_long
  task automatic t_quick;
    pr(SMT_OP_QUICK_TO_REG, 5'h00, SMT_CASE_BEST, 10'h000, 10'h002,
      10'h003, 18'h00000, 18'h00040, SMT_ADD_NONE);
    pr(SMT_OP_QUICK_TO_MEM, 5'h00, SMT_CASE_WORST, 10'h003, 10'h004,
      10'h006, 18'h00001, 18'h00041, SMT_ADD_FETCH_EA);
    pr(SMT_OP_IMM_TO_MEM, 5'h00, SMT_CASE_CACHE, 10'h003, 10'h004,
      10'h006, 18'h00001, 18'h00041, SMT_ADD_IMM_ADDR);
  endtask : t_quick
  // request held during a long divide must wait for the end
  task automatic t_refuse;
    int k;
    int seen;
    reqOp = SMT_OP_LONG_SDIVIDE;
    runCase = SMT_CASE_BEST;
    reqValid = 1'b1;
    @(posedge ref_clk); #1;
    reqOp = SMT_OP_QUICK_TO_REG;
    chk("divide", {10'h058, 10'h05A, 10'h05B},
      {bestClocks, cacheClocks, worstClocks});
    chk("busy not ready", 64'h2, {62'h0, execBusy, reqReady});
    k = 0;
    seen = 0;
    while (execDone !== 1'b1 && k < 300) begin
      @(posedge ref_clk); #1;
      k++;
      if (ansValid === 1'b1) seen++;
    end
    chk("divide cycles", 64'd88, k);
    chk("answers while busy", 64'h0, seen);
    chk("idle at done", 64'h1, {62'h0, execBusy, reqReady});
    @(posedge ref_clk); #1;
    reqValid = 1'b0;
    chk("quick after done", {1'b1, 10'h003}, {ansValid, worstClocks});
    @(posedge ref_clk); #1;
    chk("quick done", 64'h1, {63'h0, execDone});
  endtask : t_refuse
  // reset in mid-count drops the run; the next request starts clean
  task automatic t_reset;
    reqOp = SMT_OP_LONG_UDIVIDE;
    runCase = SMT_CASE_WORST;
    reqValid = 1'b1;
    @(posedge ref_clk); #1;
    reqValid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    @(posedge ref_clk); #1;
    chk("reset flags", 64'h8, {60'h0, reqReady, execBusy, ansValid, execDone});
    chk("reset figures", 64'h0, {worstClocks, worstBus, addTime});
    sys_rst = 1'b0;
    pr(SMT_OP_IMM_TO_REG, 5'h00, SMT_CASE_WORST, 10'h000, 10'h002,
      10'h003, 18'h00000, 18'h00040, SMT_ADD_IMM_ADDR);
  endtask : t_reset
  // main sequence
  initial begin
    reqValid = 1'b0;
    reqOp = SMT_OP_EXCHANGE;
    reqRegCount = 5'h00;
    runCase = SMT_CASE_BEST;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_control;
    t_multi;
    t_lane;
    t_status;
    t_long;
    t_quick;
    t_refuse;
    t_reset;
    report_and_stop;
  end
  // watchdog, far beyond the roughly five hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    report_and_stop;
  end
endmodule : tb_smt_timing_model
